// ===== src/scp_top.sv
// Three-wire serial configuration port with an Avalon-MM register view.
// Functional notes
// [RULE_01] Select fall then clock rise starts frame.
// [RULE_02] Sixteen-bit instruction, then length-coded data bytes.
// [RULE_03] Clock and data honoured only while selected.
// [RULE_04] Select may pause between bytes, frame resumes.
// [RULE_05] Length code three streams until select rises.
// [RULE_06] Select rise mid-byte aborts, awaits instruction.
// [RULE_07] Two-wire mode with select tied low.
// [RULE_08] Framing aligned to instruction after reset.
// [RULE_09] Two-wire hosts should avoid streaming.
// [RULE_10] Without select, streaming never ends.
// [RULE_11] Instruction picks register write or readback.
// [RULE_12] Readback turns data pin to output.
// [RULE_13] MSB first by default, LSB selectable.
// [RULE_14] Input data sampled on clock rise.
// [RULE_15] Index registers apply on transfer bit.
// [RULE_16] Host writes order bits in both nibbles.
// [RULE_17] Bit15 read, 14:13 length, rest address.
// [RULE_18] Address steps per byte, direction by order.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module scp_top (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_port_select_n,
    input wire logic i_sdio,
    output logic o_sdio,
    output logic o_sdio_oe,
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [7:0] o_index_a,
    output logic [7:0] o_index_b
);
    // -------------------------------------------------------------------
    // Serial clock domain: shift-in side
    // -------------------------------------------------------------------
    logic frame_rst_n;
    logic [3:0] bitcnt, next_bitcnt;
    logic in_frame;
    scp_pkg::scp_phase_e phase, next_phase, eff_phase;
    logic rd_mode, next_rd_mode, stream, next_stream, pause_ok, next_pause_ok;
    logic [1:0] left, next_left;
    logic [12:0] addr, next_addr, rd_addr, next_rd_addr, wr_addr, next_wr_addr;
    logic [12:0] step_addr;
    logic [15:0] sr, next_sr;
    logic [7:0] wr_data, next_wr_data, rx_byte;
    logic rd_tgl, next_rd_tgl, wr_tgl, next_wr_tgl;
    logic start_new, last_bit, lsb_s, lsb_first;
    logic [7:0] rd_hold;

    // Select high clears the bit position asynchronously; the frame survives only while pause_ok is set.
    assign frame_rst_n = i_resetn & ~i_port_select_n; // RULE_06

    scp_sync #(.WIDTH(1)) u_lsb_sync (
        .i_clk(i_sclk),
        .i_resetn(i_resetn),
        .i_d(lsb_first),
        .o_q(lsb_s)
    );

    always_comb begin
        start_new = (bitcnt == '0) && !in_frame && !pause_ok; // RULE_01
        eff_phase = start_new ? scp_pkg::SCP_INSTR : phase;
        next_sr = lsb_s ? {i_sdio, sr[15:1]} : {sr[14:0], i_sdio}; // RULE_13
        last_bit = (eff_phase == scp_pkg::SCP_INSTR) ? (bitcnt == scp_pkg::INSTR_LAST)
                                                      : (bitcnt == scp_pkg::BYTE_LAST);
        rx_byte = lsb_s ? next_sr[15:8] : next_sr[7:0];
        step_addr = lsb_s ? addr + scp_pkg::ADDR_STEP : addr - scp_pkg::ADDR_STEP; // RULE_18
        next_bitcnt = last_bit ? '0 : bitcnt + 4'h1;
        next_phase = phase;
        next_rd_mode = rd_mode;
        next_stream = stream;
        next_pause_ok = pause_ok;
        next_left = left;
        next_addr = addr;
        next_rd_addr = rd_addr;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_rd_tgl = rd_tgl;
        next_wr_tgl = wr_tgl;
        if (!i_port_select_n) begin // RULE_03
            next_phase = eff_phase;
            if (bitcnt == '0) begin
                next_pause_ok = 1'b0; // RULE_06
            end
            if (last_bit && eff_phase == scp_pkg::SCP_INSTR) begin
                next_rd_mode = next_sr[scp_pkg::RD_BIT]; // RULE_17
                next_left = next_sr[scp_pkg::LEN_HI:scp_pkg::LEN_LO]; // RULE_02
                next_stream = (next_left == scp_pkg::LEN_STREAM); // RULE_05
                next_addr = next_sr[scp_pkg::ADDR_W-1:0];
                next_phase = scp_pkg::SCP_DATA;
                next_pause_ok = !next_stream; // RULE_04
                if (next_rd_mode) begin // RULE_11
                    next_rd_addr = next_addr;
                    next_rd_tgl = !rd_tgl;
                end
            end else if (last_bit) begin
                if (!rd_mode) begin // RULE_11
                    next_wr_addr = addr;
                    next_wr_data = rx_byte;
                    next_wr_tgl = !wr_tgl;
                end
                next_addr = step_addr; // RULE_18
                if (stream) begin // RULE_10
                    next_rd_addr = step_addr;
                    next_rd_tgl = rd_tgl ^ rd_mode;
                end else if (left == scp_pkg::LEN_ONE) begin
                    next_phase = scp_pkg::SCP_INSTR;
                end else begin
                    next_left = left - scp_pkg::LEN_STEP;
                    next_pause_ok = 1'b1; // RULE_04
                    next_rd_addr = step_addr;
                    next_rd_tgl = rd_tgl ^ rd_mode;
                end
            end
        end
    end

    // Data is taken on the rising clock edge.
    always_ff @(posedge i_sclk or negedge frame_rst_n) begin // RULE_14
        if (!frame_rst_n) begin
            bitcnt <= '0;
            in_frame <= 1'b0;
        end else begin
            bitcnt <= next_bitcnt;
            in_frame <= 1'b1; // RULE_07
        end
    end

    // Reset leaves the port waiting for bit 15 of an instruction.
    always_ff @(posedge i_sclk or negedge i_resetn) begin // RULE_08
        if (!i_resetn) begin
            phase <= scp_pkg::SCP_INSTR;
            rd_mode <= 1'b0;
            stream <= 1'b0;
            pause_ok <= 1'b0;
            left <= '0;
            addr <= '0;
            rd_addr <= '0;
            wr_addr <= '0;
            wr_data <= '0;
            sr <= '0;
            rd_tgl <= 1'b0;
            wr_tgl <= 1'b0;
        end else begin
            phase <= next_phase;
            rd_mode <= next_rd_mode;
            stream <= next_stream;
            pause_ok <= next_pause_ok;
            left <= next_left;
            addr <= next_addr;
            rd_addr <= next_rd_addr;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            sr <= next_sr;
            rd_tgl <= next_rd_tgl;
            wr_tgl <= next_wr_tgl;
        end
    end

    // -------------------------------------------------------------------
    // Serial clock domain: readback driver on the falling edge
    // -------------------------------------------------------------------
    logic tx_rst_n, drive_q, next_drive, sdio_q, next_sdio;
    logic [7:0] tx_sh, next_tx_sh;

    // A select rise that is not a legal pause drops the driver at once.
    assign tx_rst_n = i_resetn & ~(i_port_select_n & ~pause_ok); // RULE_06

    // The byte in rd_hold was fetched after the request toggle, less than half a serial clock earlier, and is
    // held still until the next fetch, so it is read here without a synchroniser.
    always_comb begin
        next_drive = (phase == scp_pkg::SCP_DATA) && rd_mode; // RULE_12
        if (next_drive && bitcnt == '0) begin
            next_tx_sh = rd_hold;
        end else begin
            next_tx_sh = lsb_s ? (tx_sh >> 1) : (tx_sh << 1);
        end
        next_sdio = lsb_s ? next_tx_sh[0] : next_tx_sh[7]; // RULE_13
    end

    always_ff @(negedge i_sclk or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            drive_q <= 1'b0;
            tx_sh <= '0;
            sdio_q <= 1'b0;
        end else begin
            drive_q <= next_drive;
            tx_sh <= next_tx_sh;
            sdio_q <= next_sdio;
        end
    end

    assign o_sdio = sdio_q;
    // Gated by select so a paused read never holds a shared data line.
    assign o_sdio_oe = drive_q & ~i_port_select_n; // RULE_12

    // -------------------------------------------------------------------
    // System clock domain: register file and Avalon slave
    // -------------------------------------------------------------------
    logic [1:0] evt_s, evt_d;
    logic rd_ev, wr_ev, av_req, w_en;
    logic [12:0] w_addr;
    logic [7:0] w_data;
    logic [7:0] mem [scp_pkg::NREG];
    logic [7:0] next_mem [scp_pkg::NREG];
    logic [7:0] act_a, next_act_a, act_b, next_act_b, next_rd_hold, wr_count, next_wr_count;
    logic next_lsb_first, ack, next_ack;
    logic [31:0] next_rdata;

    scp_sync #(.WIDTH(2)) u_evt_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_d({rd_tgl, wr_tgl}),
        .o_q(evt_s)
    );

    function automatic logic [7:0] reg_byte(input logic [12:0] a);
        reg_byte = (a < scp_pkg::GEN_LIMIT) ? mem[a[3:0]] : scp_pkg::REG_DEFAULT;
    endfunction : reg_byte

    assign rd_ev = evt_s[1] ^ evt_d[1];
    assign wr_ev = evt_s[0] ^ evt_d[0];

    always_comb begin
        // A serial write owns the write port; the bus request waits a cycle.
        av_req = (i_avs_read || i_avs_write) && !ack && !wr_ev;
        w_en = wr_ev || (av_req && i_avs_write && i_avs_byteenable[0]
                         && i_avs_address < scp_pkg::AV_SPAN);
        w_addr = wr_ev ? wr_addr : 13'(i_avs_address[7:0]);
        w_data = wr_ev ? wr_data : i_avs_writedata[7:0];
        next_mem = mem;
        next_act_a = act_a;
        next_act_b = act_b;
        if (w_en && w_addr < scp_pkg::GEN_LIMIT) begin
            next_mem[w_addr[3:0]] = w_data;
        end
        if (w_en && w_addr == scp_pkg::ADDR_XFER && w_data[scp_pkg::XFER_BIT]) begin
            next_act_a = mem[scp_pkg::IDX_A]; // RULE_15
            next_act_b = mem[scp_pkg::IDX_B];
        end
        if (w_en && w_addr == scp_pkg::ADDR_CFG
                && (w_data[scp_pkg::CFG_SRST_HI] || w_data[scp_pkg::CFG_SRST_LO])) begin
            for (int i = 0; i < scp_pkg::NREG; i++) begin
                next_mem[i] = (i == 0) ? scp_pkg::CFG_DEFAULT : scp_pkg::REG_DEFAULT;
            end
        end
        // Either nibble's copy selects LSB-first, so a half-written setting still acts.
        next_lsb_first = next_mem[0][scp_pkg::CFG_LSB_HI]
                       | next_mem[0][scp_pkg::CFG_LSB_LO]; // RULE_16
        next_rd_hold = rd_ev ? reg_byte(rd_addr) : rd_hold; // RULE_12
        next_wr_count = wr_ev ? wr_count + 8'h01 : wr_count;
        next_ack = av_req;
        next_rdata = o_avs_readdata;
        if (av_req && i_avs_read) begin
            if (i_avs_address < scp_pkg::AV_SPAN) begin
                next_rdata = {24'h0, reg_byte(13'(i_avs_address[7:0]))};
            end else if (i_avs_address == scp_pkg::AV_STATUS) begin
                next_rdata = {16'h0, wr_count, 7'h0, lsb_first};
            end else if (i_avs_address == scp_pkg::AV_ACTIVE) begin
                next_rdata = {16'h0, act_b, act_a};
            end else begin
                next_rdata = '0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < scp_pkg::NREG; i++) begin
                mem[i] <= (i == 0) ? scp_pkg::CFG_DEFAULT : scp_pkg::REG_DEFAULT;
            end
            evt_d <= '0;
            act_a <= '0;
            act_b <= '0;
            lsb_first <= 1'b0;
            rd_hold <= '0;
            wr_count <= '0;
            ack <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
            o_index_a <= '0;
            o_index_b <= '0;
        end else begin
            mem <= next_mem;
            evt_d <= evt_s;
            act_a <= next_act_a;
            act_b <= next_act_b;
            lsb_first <= next_lsb_first;
            rd_hold <= next_rd_hold;
            wr_count <= next_wr_count;
            ack <= next_ack;
            o_avs_waitrequest <= !next_ack;
            o_avs_readdata <= next_rdata;
            o_index_a <= next_act_a;
            o_index_b <= next_act_b;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    xfer_copy_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_15
        (w_en && w_addr == scp_pkg::ADDR_XFER && w_data[scp_pkg::XFER_BIT])
        |=> (act_a == $past(mem[scp_pkg::IDX_A])) ##1 (o_index_a == $past(act_a)))
        else $error("Index register not applied on transfer.");
    index_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_15
        !(w_en && w_addr == scp_pkg::ADDR_XFER) |=> $stable(act_a) && $stable(act_b))
        else $error("Active index changed without transfer.");
    soft_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_13
        (w_en && w_addr == scp_pkg::ADDR_CFG && w_data[scp_pkg::CFG_SRST_HI])
        |=> mem[0] == scp_pkg::CFG_DEFAULT ##1 !lsb_first)
        else $error("Soft reset did not restore configuration.");
    spi_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_11
        (wr_ev && wr_addr < scp_pkg::GEN_LIMIT && wr_addr != scp_pkg::ADDR_CFG)
        |=> mem[$past(wr_addr[3:0])] == $past(wr_data))
        else $error("Serial write not stored.");
    bus_answer_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_avs_read && o_avs_waitrequest && !wr_ev && !ack) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("Bus answer not one cycle after request.");
    instr_done_a: assert property (@(posedge i_sclk) disable iff (!i_resetn) // RULE_02
        (!i_port_select_n && last_bit && eff_phase == scp_pkg::SCP_INSTR)
        |=> phase == scp_pkg::SCP_DATA && bitcnt == '0)
        else $error("Instruction did not open the data phase.");
    stream_stay_a: assert property (@(posedge i_sclk) disable iff (!i_resetn) // RULE_05
        (!i_port_select_n && stream && last_bit && eff_phase == scp_pkg::SCP_DATA)
        |=> phase == scp_pkg::SCP_DATA)
        else $error("Streaming left the data phase.");
    addr_step_a: assert property (@(posedge i_sclk) disable iff (!i_resetn) // RULE_18
        (!i_port_select_n && last_bit && eff_phase == scp_pkg::SCP_DATA && !lsb_s)
        |=> addr == $past(addr) - scp_pkg::ADDR_STEP)
        else $error("Address did not step down in MSB-first order.");
    write_launch_a: assert property (@(posedge i_sclk) disable iff (!i_resetn) // RULE_11
        (!i_port_select_n && last_bit && eff_phase == scp_pkg::SCP_DATA && !rd_mode)
        |=> wr_tgl != $past(wr_tgl) && wr_data == $past(rx_byte))
        else $error("Write byte not launched.");
endmodule : scp_top

// ===== src/scp_pkg.sv
// Constants and types shared by the serial configuration port.
package scp_pkg;
    // -------------------------------------------------------------------
    // Serial framing
    // -------------------------------------------------------------------
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam int RD_BIT = 15;
    localparam int LEN_HI = 14;
    localparam int LEN_LO = 13;
    localparam int ADDR_W = 13;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [1:0] LEN_ONE = 2'h0;
    localparam logic [1:0] LEN_STEP = 2'h1;
    localparam logic [12:0] ADDR_STEP = 13'h0001;
    // -------------------------------------------------------------------
    // Register space
    // -------------------------------------------------------------------
    localparam int NREG = 16;
    localparam logic [12:0] ADDR_CFG = 13'h0000;
    localparam logic [3:0] IDX_A = 4'h4;
    localparam logic [3:0] IDX_B = 4'h5;
    localparam logic [12:0] ADDR_XFER = 13'h00ff;
    localparam logic [12:0] GEN_LIMIT = 13'h0010;
    localparam logic [7:0] CFG_DEFAULT = 8'h18;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_SRST_HI = 5;
    localparam int CFG_SRST_LO = 2;
    localparam int XFER_BIT = 0;
    // -------------------------------------------------------------------
    // Avalon word indices
    // -------------------------------------------------------------------
    localparam logic [8:0] AV_SPAN = 9'h100;
    localparam logic [8:0] AV_STATUS = 9'h100;
    localparam logic [8:0] AV_ACTIVE = 9'h101;
    typedef enum logic {SCP_INSTR, SCP_DATA} scp_phase_e;
endpackage : scp_pkg

// ===== src/scp_sync.sv
// Two-flop synchroniser for levels and toggles.
`timescale 1ns/1ps
module scp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule : scp_sync

// ===== verification/scp_host_model.sv
// Behavioural serial host that frames instructions and data bytes on the three-wire port.
`timescale 1ns/1ps
module scp_host_model (
    input wire logic i_sdio,
    output logic o_sclk,
    output logic o_port_select_n,
    output logic o_sdio,
    output logic o_sdio_oe
);
    localparam realtime HALF = 62.5;
    logic lsb_first;
    initial begin
        o_sclk = 1'b0;
        o_port_select_n = 1'b0;
        o_sdio = 1'b0;
        o_sdio_oe = 1'b0;
        lsb_first = 1'b0;
    end
    // Data changes while the clock is low, a half period ahead of the rising edge.
    task automatic shift_bit(input logic drive, input logic b, output logic r);
        o_sdio_oe = drive;
        o_sdio = b;
        #HALF o_sclk = 1'b1;
        r = i_sdio;
        #HALF o_sclk = 1'b0;
    endtask : shift_bit
    task automatic shift_byte(input logic drive, input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 0; i < 8; i++) begin
            shift_bit(drive, lsb_first ? d[i] : d[7-i], r);
            q[lsb_first ? i : 7-i] = r;
        end
    endtask : shift_byte
    task automatic instr(input logic [15:0] w);
        logic [7:0] q;
        shift_byte(1'b1, lsb_first ? w[7:0] : w[15:8], q);
        shift_byte(1'b1, lsb_first ? w[15:8] : w[7:0], q);
    endtask : instr
    // The select only moves while the clock is low, so each byte ends on a falling edge.
    task automatic sel(input logic v);
        o_port_select_n = v;
        #HALF;
    endtask : sel
    // Clock pulses with select high let the order setting reach the link domain.
    task automatic idle_pulses(input int n);
        repeat (n) begin
            #HALF o_sclk = 1'b1;
            #HALF o_sclk = 1'b0;
        end
    endtask : idle_pulses
endmodule : scp_host_model

// ===== verification/tb_serial_config_port.sv
// Self-checking testbench for the serial configuration port.
`timescale 1ns/1ps
module tb_serial_config_port;
    logic i_clk;
    logic i_resetn;
    logic sclk;
    logic sel_n;
    logic host_sdio;
    logic host_oe;
    logic dev_sdio;
    logic dev_oe;
    logic sdio_wire;
    logic [8:0] av_address;
    logic av_read;
    logic av_write;
    logic [31:0] av_writedata;
    logic [3:0] av_byteenable;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    logic [7:0] index_a;
    logic [7:0] index_b;
    logic [7:0] rxq[$];
    logic [31:0] rd;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    // The pin has a pull-down, so a released line reads low.
    assign sdio_wire = dev_oe ? dev_sdio : (host_oe ? host_sdio : 1'b0);
    scp_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk),
        .i_port_select_n(sel_n), .i_sdio(sdio_wire), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe),
        .i_avs_address(av_address), .i_avs_read(av_read), .i_avs_write(av_write),
        .i_avs_writedata(av_writedata), .i_avs_byteenable(av_byteenable),
        .o_avs_readdata(av_readdata), .o_avs_waitrequest(av_waitrequest),
        .o_index_a(index_a), .o_index_b(index_b));
    scp_host_model host (.i_sdio(sdio_wire), .o_sclk(sclk), .o_port_select_n(sel_n),
        .o_sdio(host_sdio), .o_sdio_oe(host_oe));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures = failures + 1;
            conclude();
        end
    end
    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Request held from just after an edge until waitrequest is sampled low.
    task automatic av_access(input logic w, input logic [8:0] a, input logic [31:0] d,
                             input logic [3:0] be);
        @(posedge i_clk);
        av_address <= a;
        av_writedata <= d;
        av_byteenable <= be;
        av_write <= w;
        av_read <= !w;
        do @(posedge i_clk); while (av_waitrequest !== 1'b0);
        rd = av_readdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask : av_access
    task automatic reg_check(input logic [8:0] a, input logic [7:0] exp);
        av_access(1'b0, a, 32'h0, 4'hf);
        check(rd, {24'h0, exp});
    endtask : reg_check
    task automatic frame(input logic rdn, input logic [1:0] len, input logic [12:0] a,
                         input logic [7:0] d[$], input bit pause, input bit tw);
        logic [7:0] q;
        rxq = {};
        if (!tw) host.sel(1'b0);
        host.instr({rdn, len, a});
        foreach (d[i]) begin
            if (pause && i > 0) begin
                host.sel(1'b1);
                host.sel(1'b0);
            end
            host.shift_byte(!rdn, d[i], q);
            rxq.push_back(q);
        end
        if (!tw) host.sel(1'b1);
        repeat (8) @(posedge i_clk);
    endtask : frame
    // -------------------------------------------------------------------
    // Sequence
    // -------------------------------------------------------------------
    initial begin
        logic r;
        i_resetn = 1'b0;
        av_address = 9'h0;
        av_read = 1'b0;
        av_write = 1'b0;
        av_writedata = 32'h0;
        av_byteenable = 4'hf;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            reg_check(9'(i), i == 0 ? scp_pkg::CFG_DEFAULT : scp_pkg::REG_DEFAULT);
        end
        check({16'h0, index_b, index_a}, 32'h0);
        av_access(1'b1, 9'h1f0, 32'h5a, 4'hf);
        reg_check(9'h1f0, 8'h00);
        av_access(1'b1, 9'h001, 32'h77, 4'he);
        reg_check(9'h001, 8'h00);
        // Select has been low since reset: two-wire frames, then a stream nothing ends.
        frame(1'b0, scp_pkg::LEN_ONE, 13'h3, {8'ha5}, 0, 1);
        frame(1'b0, scp_pkg::LEN_STREAM, 13'hc, {8'h11, 8'h22, 8'h33}, 0, 1);
        host.sel(1'b1);
        reg_check(9'h003, 8'ha5);
        reg_check(9'h00a, 8'h33);
        frame(1'b0, 2'h2, 13'h9, {8'h81, 8'h42, 8'hc3}, 1, 0);
        reg_check(9'h007, 8'hc3);
        frame(1'b1, 2'h1, 13'h9, {8'h0, 8'h0}, 1, 0);
        check({16'h0, rxq[0], rxq[1]}, 32'h8142);
        check({31'h0, dev_oe}, 32'h0);
        // A select rise four bits into a byte throws the frame away.
        host.sel(1'b0);
        host.instr({1'b0, 2'h0, 13'h2});
        repeat (4) host.shift_bit(1'b1, 1'b1, r);
        host.sel(1'b1);
        frame(1'b0, 2'h0, 13'h2, {8'h99}, 0, 0);
        reg_check(9'h002, 8'h99);
        frame(1'b0, scp_pkg::LEN_STREAM, 13'hf, {8'hde, 8'had, 8'hbe}, 0, 0);
        reg_check(9'h00d, 8'hbe);
        reg_check(9'h00e, 8'had);
        // A streamed readback walks down from the start address until select rises.
        frame(1'b1, scp_pkg::LEN_STREAM, 13'hf, {8'h0, 8'h0, 8'h0}, 0, 0);
        check({8'h0, rxq[0], rxq[1], rxq[2]}, 32'h00deadbe);
        check({31'h0, dev_oe}, 32'h0);
        frame(1'b0, 2'h1, 13'h5, {8'h5b, 8'h4a}, 0, 0);
        check({16'h0, index_b, index_a}, 32'h0);
        reg_check(9'h004, 8'h4a);
        frame(1'b0, 2'h0, 13'hff, {8'h01}, 0, 0);
        check({16'h0, index_b, index_a}, 32'h5b4a);
        av_access(1'b0, 9'h101, 32'h0, 4'hf);
        check(rd, 32'h5b4a);
        reg_check(9'h0ff, 8'h00);
        // Order bits set in both nibbles, as the host is expected to write them.
        frame(1'b0, 2'h0, 13'h0, {8'h5a}, 0, 0);
        host.lsb_first = 1'b1;
        host.idle_pulses(3);
        frame(1'b0, 2'h1, 13'h1, {8'h12, 8'h34}, 0, 0);
        reg_check(9'h001, 8'h12);
        reg_check(9'h002, 8'h34);
        frame(1'b1, 2'h0, 13'h2, {8'h0}, 0, 0);
        check({24'h0, rxq[0]}, 32'h34);
        av_access(1'b0, 9'h100, 32'h0, 4'hf);
        // Seventeen serial bytes have been written by now, and LSB-first is on.
        check(rd, 32'h1101);
        frame(1'b0, 2'h0, 13'h0, {8'h3c}, 0, 0);
        reg_check(9'h000, 8'h18);
        reg_check(9'h001, 8'h00);
        conclude();
    end
endmodule : tb_serial_config_port
